// ==== rtl/dct_dma_ctrl.v ====
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "dct_defines.vh"

// Overview of operation
// - configuration error leaves source, destination and count as written
// - configuration error sets config and abnormal flags together
// - both sides marked as I/O is a configuration error
// - start with normal or abnormal flag still set aborts with config error
// - count or addresses not multiple of unit size is a config error
// - port size wider than transfer unit is a config error
// - start with zero byte count aborts with config error
// - bus error sets source or destination bus error plus abnormal flag
// - bus error during transfer is reported to the processor core
// - four channels, lowest numbered requesting channel always served first
// - internal requests stay pending until count zero or a bus error ends the channel
// - higher request suspends lower channel, which resumes afterwards
// - channel switch only after whole unit written to destination
// - normal completion sets flag and raises enabled interrupt
// - abnormal completion sets flag and raises enabled interrupt
// - narrow port gathers reads into or splits writes from holding register
// - packing is little-endian, first access in lowest lane
// - all state changes on rising clock edge
// - memory-to-memory repeats units after one request until count zero
// - normal end only when count zero and last unit completed
// - start passing checks sets the active flag
// - port size above transfer unit is invalid
module dct_dma_ctrl (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] ext_req,
  output wire [3:0] dma_ack,
  output reg bus_req,
  output reg bus_we,
  output reg [31:0] bus_addr,
  output reg [1:0] bus_size,
  output reg [31:0] bus_wdata,
  input wire bus_ack,
  input wire bus_err,
  input wire [31:0] bus_rdata,
  output wire [3:0] irq_normal,
  output wire [3:0] irq_abnormal,
  output wire [3:0] bus_err_irq
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_READ = 2'h1;
  localparam [1:0] ST_WRITE = 2'h2;

  // ************************************************************
  // helper functions
  // ************************************************************
  // byte width of a size code
  function [2:0] size_bytes;
    input [1:0] code;
    begin
      if (code == `DCT_SZ_8) begin
        size_bytes = 3'h1;
      end else if (code == `DCT_SZ_16) begin
        size_bytes = 3'h2;
      end else begin
        size_bytes = 3'h4;
      end
    end
  endfunction

  // lane mask of a byte width
  function [31:0] lane_mask;
    input [2:0] nbytes;
    begin
      if (nbytes == 3'h1) begin
        lane_mask = 32'h000000FF;
      end else if (nbytes == 3'h2) begin
        lane_mask = 32'h0000FFFF;
      end else begin
        lane_mask = 32'hFFFFFFFF;
      end
    end
  endfunction

  // byte-enable merge of a register write
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge[k*8 +: 8] = data[k*8 +: 8];
        end
      end
    end
  endfunction

  // configuration check at start
  function cfg_err;
    input [`DCT_CTL_W-1:0] ctl;
    input [`DCT_STS_W-1:0] sts;
    input [31:0] src;
    input [31:0] dst;
    input [31:0] cnt;
    reg [2:0] ub;
    reg [2:0] pb;
    reg [1:0] m;
    begin
      ub = size_bytes(ctl[`DCT_CTL_UNIT_LSB +: 2]);
      pb = size_bytes(ctl[`DCT_CTL_PORT_LSB +: 2]);
      m = ub[1:0] - 2'h1;
      cfg_err =
        (ctl[`DCT_CTL_SRC_IO] & ctl[`DCT_CTL_DST_IO]) |
        sts[`DCT_STS_NC] | sts[`DCT_STS_ABN] |
        (|(cnt[1:0] & m)) | (|(src[1:0] & m)) | (|(dst[1:0] & m)) |
        (pb > ub) |
        (cnt == 32'h00000000);
    end
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  reg [31:0] src_ff [0:3];
  reg [31:0] dst_ff [0:3];
  reg [31:0] cnt_ff [0:3];
  reg [`DCT_CTL_W-1:0] ctl_ff [0:3];
  reg [`DCT_STS_W-1:0] sts_ff [0:3];
  reg [3:0] pend_ff;
  reg [3:0] ack_ff;
  reg [1:0] state_ff;
  reg [1:0] cur_ff;
  reg [1:0] beat_ff;
  reg [31:0] hold_ff;
  reg aw_hold_ff;
  reg [31:0] aw_addr_ff;
  reg w_hold_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;

  // ************************************************************
  // axi handshakes
  // ************************************************************
  assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_hold_ff & ~bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign dma_ack = ack_ff;

  wire do_write = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  wire [1:0] wr_ch = aw_addr_ff[6:5];
  wire [4:0] wr_off = aw_addr_ff[4:0];
  wire [31:0] ctl_wr = merge({22'h000000, ctl_ff[wr_ch]}, w_data_ff, w_strb_ff);
  wire wr_hit = (aw_addr_ff[31:`DCT_MAP_TOP_LSB] == 25'h0000000) &&
    (wr_off <= `DCT_OFF_STS);
  wire do_read = s_axi_arvalid & ~rvalid_ff;
  wire [1:0] rd_ch = s_axi_araddr[6:5];
  wire [4:0] rd_off = s_axi_araddr[4:0];
  wire rd_hit = (s_axi_araddr[31:`DCT_MAP_TOP_LSB] == 25'h0000000) &&
    (rd_off <= `DCT_OFF_STS) && (rd_off[1:0] == 2'h0);

  // read data mux, start bit reads as zero
  reg [31:0] rd_word;
  always @* begin
    case (rd_off)
      `DCT_OFF_SRC: rd_word = src_ff[rd_ch];
      `DCT_OFF_DST: rd_word = dst_ff[rd_ch];
      `DCT_OFF_CNT: rd_word = cnt_ff[rd_ch];
      `DCT_OFF_CTL: rd_word = {22'h000000, ctl_ff[rd_ch][`DCT_CTL_W-1:1], 1'b0};
      `DCT_OFF_STS: rd_word = {26'h0000000, sts_ff[rd_ch]};
      default: rd_word = 32'h00000000;
    endcase
  end

  // ************************************************************
  // current channel decode
  // ************************************************************
  wire [`DCT_CTL_W-1:0] cur_ctl = ctl_ff[cur_ff];
  wire src_io = cur_ctl[`DCT_CTL_SRC_IO];
  wire dst_io = cur_ctl[`DCT_CTL_DST_IO];
  wire [2:0] unit_b = size_bytes(cur_ctl[`DCT_CTL_UNIT_LSB +: 2]);
  wire [2:0] port_b = size_bytes(cur_ctl[`DCT_CTL_PORT_LSB +: 2]);
  wire [4:0] off_prod = beat_ff * port_b;
  wire [2:0] off_b = off_prod[2:0];
  wire [2:0] end_b = off_b + port_b;
  wire last_beat = (end_b == unit_b);
  wire [5:0] lane_sh = {off_b, 3'b000};
  wire [31:0] io_rdata = (bus_rdata & lane_mask(port_b)) << lane_sh;
  wire [31:0] mem_rdata = bus_rdata & lane_mask(unit_b);
  wire [31:0] cnt_left = cnt_ff[cur_ff] - {29'h00000000, unit_b};

  reg [3:0] want;
  reg grant_any;
  reg [1:0] grant_ch;
  integer g;
  always @* begin
    want = 4'h0;
    grant_any = 1'b0;
    grant_ch = 2'h0;
    for (g = 0; g < 4; g = g + 1) begin
      want[g] = pend_ff[g] & sts_ff[g][`DCT_STS_ACT];
    end
    for (g = 3; g >= 0; g = g - 1) begin
      if (want[g]) begin
        grant_any = 1'b1;
        grant_ch = g[1:0];
      end
    end
  end

  // bus cycle drive from engine state
  always @* begin
    bus_req = 1'b0;
    bus_we = 1'b0;
    bus_addr = 32'h00000000;
    bus_size = cur_ctl[`DCT_CTL_UNIT_LSB +: 2];
    bus_wdata = 32'h00000000;
    case (state_ff)
      ST_READ: begin
        bus_req = 1'b1;
        bus_addr = src_ff[cur_ff];
        if (src_io) begin
          bus_size = cur_ctl[`DCT_CTL_PORT_LSB +: 2];
        end
      end
      ST_WRITE: begin
        bus_req = 1'b1;
        bus_we = 1'b1;
        bus_addr = dst_ff[cur_ff];
        bus_wdata = hold_ff;
        if (dst_io) begin
          bus_size = cur_ctl[`DCT_CTL_PORT_LSB +: 2];
          bus_wdata = (hold_ff >> lane_sh) & lane_mask(port_b);
        end
      end
      default: begin
        bus_req = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // interrupt and error notification levels
  // ************************************************************
  genvar c;
  generate
    for (c = 0; c < 4; c = c + 1) begin : g_irq
      assign irq_normal[c] = sts_ff[c][`DCT_STS_NC] & ctl_ff[c][`DCT_CTL_NIE];
      assign irq_abnormal[c] = sts_ff[c][`DCT_STS_ABN] & ctl_ff[c][`DCT_CTL_AIE];
      assign bus_err_irq[c] = sts_ff[c][`DCT_STS_SBE] | sts_ff[c][`DCT_STS_DBE];
    end
  endgenerate

  // ************************************************************
  // axi slave sequencing
  // ************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= 32'h00000000;
      w_hold_ff <= 1'b0;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `DCT_RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `DCT_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (wr_hit && wr_off[1:0] == 2'h0) ? `DCT_RESP_OKAY : `DCT_RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
      if (do_read) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_hit ? rd_word : 32'h00000000;
        rresp_ff <= rd_hit ? `DCT_RESP_OKAY : `DCT_RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ************************************************************
  // channel registers and transfer engine
  // ************************************************************
  // one rising-edge process
  integer i;
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < 4; i = i + 1) begin
        src_ff[i] <= 32'h00000000;
        dst_ff[i] <= 32'h00000000;
        cnt_ff[i] <= 32'h00000000;
        ctl_ff[i] <= `DCT_CTL_RST;
        sts_ff[i] <= `DCT_STS_RST;
      end
      pend_ff <= 4'h0;
      ack_ff <= 4'h0;
      state_ff <= ST_IDLE;
      cur_ff <= 2'h0;
      beat_ff <= 2'h0;
      hold_ff <= 32'h00000000;
    end else begin
      ack_ff <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        if (sts_ff[i][`DCT_STS_ACT] && (ctl_ff[i][`DCT_CTL_INTREQ] || ext_req[i])) begin
          pend_ff[i] <= 1'b1;
        end
      end
      // software writes; address setup ignored while active
      if (do_write && wr_hit && !sts_ff[wr_ch][`DCT_STS_ACT]) begin
        case (wr_off)
          `DCT_OFF_SRC: src_ff[wr_ch] <= merge(src_ff[wr_ch], w_data_ff, w_strb_ff);
          `DCT_OFF_DST: dst_ff[wr_ch] <= merge(dst_ff[wr_ch], w_data_ff, w_strb_ff);
          `DCT_OFF_CNT: cnt_ff[wr_ch] <= merge(cnt_ff[wr_ch], w_data_ff, w_strb_ff);
          `DCT_OFF_CTL: begin
            ctl_ff[wr_ch] <= {ctl_wr[`DCT_CTL_W-1:1], 1'b0};
            if (w_strb_ff[0] && w_data_ff[`DCT_CTL_START]) begin
              if (cfg_err(ctl_wr[`DCT_CTL_W-1:0],
                  sts_ff[wr_ch], src_ff[wr_ch], dst_ff[wr_ch], cnt_ff[wr_ch])) begin
                sts_ff[wr_ch][`DCT_STS_CONF] <= 1'b1;
                sts_ff[wr_ch][`DCT_STS_ABN] <= 1'b1;
              end else begin
                sts_ff[wr_ch][`DCT_STS_ACT] <= 1'b1;
              end
            end
          end
          `DCT_OFF_STS: begin
            // write one to clear, engine set below wins
            if (w_strb_ff[0]) begin
              sts_ff[wr_ch] <= sts_ff[wr_ch] & ~(w_data_ff[`DCT_STS_W-1:0] & `DCT_STS_CLR_MASK);
            end
          end
          default: begin
            hold_ff <= hold_ff;
          end
        endcase
      end
      case (state_ff)
        ST_IDLE: begin
          if (grant_any) begin
            cur_ff <= grant_ch;
            beat_ff <= 2'h0;
            hold_ff <= 32'h00000000;
            state_ff <= ST_READ;
          end
        end
        ST_READ: begin
          if (bus_ack && bus_err) begin
            sts_ff[cur_ff][`DCT_STS_SBE] <= 1'b1;
            sts_ff[cur_ff][`DCT_STS_ABN] <= 1'b1;
            sts_ff[cur_ff][`DCT_STS_ACT] <= 1'b0;
            pend_ff[cur_ff] <= 1'b0;
            state_ff <= ST_IDLE;
          end else if (bus_ack) begin
            if (src_io) begin
              hold_ff <= hold_ff | io_rdata;
            end else begin
              hold_ff <= mem_rdata;
            end
            if (src_io && !last_beat) begin
              beat_ff <= beat_ff + 2'h1;
            end else begin
              beat_ff <= 2'h0;
              state_ff <= ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          if (bus_ack && bus_err) begin
            sts_ff[cur_ff][`DCT_STS_DBE] <= 1'b1;
            sts_ff[cur_ff][`DCT_STS_ABN] <= 1'b1;
            sts_ff[cur_ff][`DCT_STS_ACT] <= 1'b0;
            pend_ff[cur_ff] <= 1'b0;
            state_ff <= ST_IDLE;
          end else if (bus_ack && dst_io && !last_beat) begin
            beat_ff <= beat_ff + 2'h1;
          end else if (bus_ack) begin
            // unit done; I/O side keeps its address
            state_ff <= ST_IDLE;
            beat_ff <= 2'h0;
            cnt_ff[cur_ff] <= cnt_left;
            if (!src_io) begin
              src_ff[cur_ff] <= src_ff[cur_ff] + {29'h00000000, unit_b};
            end
            if (!dst_io) begin
              dst_ff[cur_ff] <= dst_ff[cur_ff] + {29'h00000000, unit_b};
            end
            if (cnt_left == 32'h00000000) begin
              sts_ff[cur_ff][`DCT_STS_NC] <= 1'b1;
              sts_ff[cur_ff][`DCT_STS_ACT] <= 1'b0;
              pend_ff[cur_ff] <= 1'b0;
              ack_ff[cur_ff] <= 1'b1;
            end else if ((src_io || dst_io) && !cur_ctl[`DCT_CTL_INTREQ]) begin
              // one unit per external I/O request
              pend_ff[cur_ff] <= 1'b0;
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // dct_dma_ctrl

`default_nettype wire

// ==== common/dct_defines.vh ====
`ifndef DCT_DEFINES_VH
`define DCT_DEFINES_VH

// ************************************************************
// register map: channel n window at n*0x20, bits [6:5]
// ************************************************************
`define DCT_MAP_TOP_LSB 7
`define DCT_OFF_SRC 5'h00
`define DCT_OFF_DST 5'h04
`define DCT_OFF_CNT 5'h08
`define DCT_OFF_CTL 5'h0C
`define DCT_OFF_STS 5'h10

// ************************************************************
// channel_control_reg fields
// ************************************************************
`define DCT_CTL_START 0
`define DCT_CTL_SRC_IO 1
`define DCT_CTL_DST_IO 2
`define DCT_CTL_UNIT_LSB 3
`define DCT_CTL_PORT_LSB 5
`define DCT_CTL_NIE 7
`define DCT_CTL_AIE 8
`define DCT_CTL_INTREQ 9
`define DCT_CTL_W 10
`define DCT_CTL_RST 10'h000

// ************************************************************
// channel_status_reg fields
// ************************************************************
`define DCT_STS_ACT 0
`define DCT_STS_NC 1
`define DCT_STS_ABN 2
`define DCT_STS_CONF 3
`define DCT_STS_SBE 4
`define DCT_STS_DBE 5
`define DCT_STS_W 6
`define DCT_STS_RST 6'h00
`define DCT_STS_CLR_MASK 6'h3E

// ************************************************************
// size codes, bus responses
// ************************************************************
`define DCT_SZ_32 2'h0
`define DCT_SZ_16 2'h2
`define DCT_SZ_8 2'h3
`define DCT_RESP_OKAY 2'h0
`define DCT_RESP_SLVERR 2'h2

`endif

// ==== bench/dct_dma_ctrl_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// protocol checks on the dma engine ports
// ************************************************************
module dct_dma_ctrl_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [3:0] dma_ack,
  input wire logic bus_req,
  input wire logic bus_we,
  input wire logic [31:0] bus_addr,
  input wire logic [1:0] bus_size,
  input wire logic bus_ack,
  input wire logic bus_err,
  input wire logic [3:0] irq_normal,
  input wire logic [3:0] bus_err_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic err_seen;
  logic wr_done;
  // finished bus cycles
  assign err_seen = bus_req && bus_ack && bus_err;
  assign wr_done = bus_req && bus_ack && bus_we && !bus_err;
  property p_ack_pulse;
    dma_ack != 4'h0 |-> $onehot(dma_ack) ##1 dma_ack == 4'h0;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("completion pulse not single");
  property p_req_hold;
    bus_req && !bus_ack |=> bus_req && $stable(bus_addr) && $stable(bus_we) && $stable(bus_size);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("bus cycle changed before ack");
  property p_req_end;
    $fell(bus_req) |-> $past(bus_ack);
  endproperty
  a_req_end: assert property (p_req_end) else $error("bus cycle dropped without ack");
  property p_err_flag;
    err_seen |-> ##[1:2] bus_err_irq != 4'h0;
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("bus error not reported");
  property p_err_cause;
    $rose(|bus_err_irq) |-> $past(err_seen) || $past(err_seen, 2);
  endproperty
  a_err_cause: assert property (p_err_cause) else $error("bus error flag without error");
  property p_done_after_write;
    dma_ack != 4'h0 |-> $past(wr_done) || $past(wr_done, 2);
  endproperty
  a_done_after_write: assert property (p_done_after_write) else $error("done without last write");
  property p_err_idle;
    err_seen |=> !bus_req;
  endproperty
  a_err_idle: assert property (p_err_idle) else $error("bus cycle right after abort");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  c_done: cover property (dma_ack != 4'h0);
  c_err: cover property (err_seen);
  c_irq: cover property (irq_normal != 4'h0);
endmodule // dct_dma_ctrl_properties
bind dct_dma_ctrl dct_dma_ctrl_properties u_props (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .dma_ack, .bus_req, .bus_we, .bus_addr, .bus_size,
  .bus_ack, .bus_err, .irq_normal, .bus_err_irq
);
`default_nettype wire

// ==== bench/dct_bus_mem.sv ====
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// system bus memory with an i/o port at 0xF0000000
// ************************************************************
module dct_bus_mem (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bus_req,
  input wire logic bus_we,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic [31:0] err_addr,
  output logic bus_ack,
  output logic bus_err,
  output logic [31:0] bus_rdata
);
  logic [31:0] mem [0:255];
  logic [15:0] io_cnt = 16'h0;
  logic [31:0] io_last = 32'h0;
  logic [1:0] wait_ff;
  logic is_io;
  assign is_io = bus_addr[31:28] == 4'hF;
  // answer each cycle after 0 to 2 wait cycles, data line toggles when idle
  always @(posedge aclk) begin
    bus_ack <= 1'b0;
    bus_err <= 1'b0;
    bus_rdata <= ~bus_rdata;
    if (!aresetn) begin
      wait_ff <= 2'h0;
      bus_rdata <= 32'h0;
    end else if (bus_req && !bus_ack) begin
      if (wait_ff != 2'h0) begin
        wait_ff <= wait_ff - 2'h1;
      end else begin
        wait_ff <= 2'($urandom_range(2));
        bus_ack <= 1'b1;
        bus_err <= bus_addr == err_addr;
        if (bus_we && is_io) io_last <= bus_wdata;
        else if (bus_we) mem[bus_addr[9:2]] <= bus_wdata;
        else if (is_io) begin
          // upper bits are junk the engine must ignore
          bus_rdata <= {~io_cnt, io_cnt};
          io_cnt <= io_cnt + 16'h1;
        end else bus_rdata <= mem[bus_addr[9:2]];
      end
    end
  end
endmodule // dct_bus_mem
`default_nettype wire

// ==== bench/dma_channel_termination_priority_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "dct_defines.vh"
module dma_channel_termination_priority_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [3:0] ext_req = 4'h0;
  logic [31:0] err_addr = 32'hFFFF_FFFF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, bus_size;
  logic [31:0] s_axi_rdata, bus_addr, bus_wdata, bus_rdata;
  logic bus_req, bus_we, bus_ack, bus_err;
  logic [3:0] dma_ack, irq_normal, irq_abnormal, bus_err_irq, seen_ack;
  logic [31:0] rd_d, n;
  logic [1:0] rd_r, wr_r;
  logic [15:0] c16;
  int num_errors = 0;
  int comparisons = 0;
  // config error cases: source, destination, count, control
  logic [31:0] ce [7][4] = '{'{32'h100, 32'h200, 32'h4, 32'h106},
    '{32'h100, 32'h200, 32'h0, 32'h100}, '{32'h100, 32'h200, 32'h6, 32'h100},
    '{32'h101, 32'h200, 32'h4, 32'h150}, '{32'h100, 32'h200, 32'h4, 32'h112},
    '{32'h100, 32'h200, 32'h4, 32'h158}, '{32'h100, 32'h202, 32'h4, 32'h100}};
  // ************************************************************
  // clock, dut and bus partner
  // ************************************************************
  always #5 aclk = ~aclk;
  dct_dma_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ext_req, .dma_ack, .bus_req, .bus_we, .bus_addr, .bus_size,
    .bus_wdata, .bus_ack, .bus_err, .bus_rdata, .irq_normal, .irq_abnormal, .bus_err_irq);
  dct_bus_mem u_mem (.aclk, .aresetn, .bus_req, .bus_we, .bus_addr, .bus_wdata, .err_addr,
    .bus_ack, .bus_err, .bus_rdata);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // axi write, each channel released at the edge that takes it
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    b_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!b_ok) begin
      @(negedge aclk);
      aw_ok = s_axi_awvalid & s_axi_awready;
      w_ok = s_axi_wvalid & s_axi_wready;
      b_ok = s_axi_bvalid;
      wr_r = s_axi_bresp;
      @(posedge aclk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
  endtask
  task automatic rd(input logic [31:0] a);
    logic ar_ok, r_ok;
    r_ok = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!r_ok) begin
      @(negedge aclk);
      ar_ok = s_axi_arvalid & s_axi_arready;
      r_ok = s_axi_rvalid;
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
      @(posedge aclk);
      if (ar_ok) s_axi_arvalid <= 1'b0;
    end
  endtask
  function automatic logic [31:0] ra(input int c, input int o);
    return 32'(c * 32 + o);
  endfunction
  task automatic rc(input logic [31:0] a, input logic [31:0] exp);
    rd(a);
    check(rd_d, exp);
  endtask
  task automatic setup(input int c, input logic [31:0] s, d, k, t);
    wr(ra(c, `DCT_OFF_SRC), s);
    wr(ra(c, `DCT_OFF_DST), d);
    wr(ra(c, `DCT_OFF_CNT), k);
    wr(ra(c, `DCT_OFF_CTL), t);
  endtask
  // wait for completion or bus error of the masked channels
  task automatic wait_end(input logic [3:0] m);
    int k;
    k = 0;
    do begin
      @(negedge aclk);
      seen_ack = dma_ack;
      k++;
    end while (((dma_ack | bus_err_irq) & m) == 4'h0 && k < 3000);
    if (k >= 3000) num_errors++;
    @(posedge aclk);
  endtask
  // little-endian packing of successive i/o beats
  function automatic logic [31:0] pack(input logic [15:0] c, input int w);
    logic [31:0] v;
    v = 32'h0;
    for (int k = 0; k < 32 / w; k++) v = v | ((32'(c + 16'(k)) & ((32'h1 << w) - 1)) << (k * w));
    return v;
  endfunction
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    test_done();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    void'($urandom(87));
    for (int i = 0; i < 256; i++) u_mem.mem[i] = $urandom;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(32'h80);
    check({rd_r, rd_d[29:0]}, 32'h8000_0000);
    wr(32'h80, 32'h0);
    check({30'h0, wr_r}, 32'h2);
    for (int i = 0; i < 7; i++) begin
      setup(2, ce[i][0], ce[i][1], ce[i][2], ce[i][3] | 32'h1);
      rc(ra(2, `DCT_OFF_STS), 32'h0C);
      check({28'h0, irq_abnormal}, 32'h4);
      for (int j = 0; j < 3; j++) rc(ra(2, j * 4), ce[i][j]);
      wr(ra(2, `DCT_OFF_STS), 32'h3E);
    end
    n = 32'(16 + 4 * $urandom_range(4));
    setup(1, 32'h100, 32'h200, n, 32'h281);
    rc(ra(1, `DCT_OFF_STS), 32'h1);
    wait_end(4'h2);
    check({28'h0, seen_ack}, 32'h2);
    for (int i = 0; i < n / 4; i++) check(u_mem.mem[128 + i], u_mem.mem[64 + i]);
    rc(ra(1, `DCT_OFF_STS), 32'h2);
    check({28'h0, irq_normal}, 32'h2);
    rc(ra(1, `DCT_OFF_CNT), 32'h0);
    wr(ra(1, `DCT_OFF_CTL), 32'h281);
    rc(ra(1, `DCT_OFF_STS), 32'h0E);
    wr(ra(1, `DCT_OFF_STS), 32'h3E);
    for (int p = 0; p < 2; p++) begin
      c16 = u_mem.io_cnt;
      setup(3, 32'hF000_0000, 32'h300, 32'h4, p ? 32'h2C3 : 32'h2E3);
      wait_end(4'h8);
      check(u_mem.mem[192], pack(c16, p ? 16 : 8));
      wr(ra(3, `DCT_OFF_STS), 32'h3E);
    end
    setup(3, 32'h300, 32'hF000_0000, 32'h4, 32'h2C5);
    wait_end(4'h8);
    check({16'h0, u_mem.io_last[15:0]}, {16'h0, u_mem.mem[192][31:16]});
    wr(ra(3, `DCT_OFF_STS), 32'h3E);
    for (int e = 0; e < 2; e++) begin
      err_addr <= e ? 32'h204 : 32'h104;
      setup(0, 32'h100, 32'h200, 32'h8, 32'h301);
      wait_end(4'h1);
      rc(ra(0, `DCT_OFF_STS), e ? 32'h24 : 32'h14);
      check({28'h0, bus_err_irq}, 32'h1);
      check({28'h0, irq_abnormal}, 32'h1);
      wr(ra(0, `DCT_OFF_STS), 32'h3E);
      rc(ra(0, `DCT_OFF_STS), 32'h0);
    end
    err_addr <= 32'hFFFF_FFFF;
    setup(0, 32'hF000_0000, 32'h380, 32'h4, 32'h83);
    setup(1, 32'h100, 32'h240, 32'h20, 32'h281);
    repeat (6) @(posedge aclk);
    ext_req <= 4'h1;
    wait_end(4'h3);
    ext_req <= 4'h0;
    check({28'h0, seen_ack}, 32'h1);
    wait_end(4'h2);
    check({28'h0, seen_ack}, 32'h2);
    for (int i = 0; i < 8; i++) check(u_mem.mem[144 + i], u_mem.mem[64 + i]);
    test_done();
  end
endmodule // dma_channel_termination_priority_test
`default_nettype wire
